// ===== design/rtw_pkg.sv
package rtw_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_STATUS = 8'h78;
   localparam logic [7:0] ADDR_MASK = 8'h79;
   localparam logic [7:0] ADDR_COUNT = 8'h7c;
   localparam logic [7:0] ADDR_RELOAD = 8'h7d;
   localparam logic [7:0] ADDR_CONTROL = 8'h7e;

   // Control field positions
   localparam int CTL_SEL_LSB = 0;
   localparam int CTL_RUN_BIT = 3;
   localparam int CTL_ONE_BIT = 4;
   localparam int CTL_GRUN_BIT = 5;
   localparam int CTL_NEXT_BIT = 6;
   localparam int CTL_MODE_BIT = 7;

   // Status and mask bit of the overflow event
   localparam int STAT_OVF_BIT = 0;

   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h10;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;

   // Service codes, low nibble
   localparam logic [3:0] SERVICE_FIRST = 4'h3;
   localparam logic [3:0] SERVICE_SECOND = 4'hc;

   localparam logic [7:0] COUNT_MAX = 8'hff;

   // Prescaler tap masks: divisor minus one of the timebase clock
   localparam int PRESC_W = 12;
   localparam logic [11:0] TAP_DIV8 = 12'h007;
   localparam logic [11:0] TAP_DIV16 = 12'h00f;
   localparam logic [11:0] TAP_DIV32 = 12'h01f;
   localparam logic [11:0] TAP_DIV64 = 12'h03f;
   localparam logic [11:0] TAP_DIV128 = 12'h07f;
   localparam logic [11:0] TAP_DIV256 = 12'h0ff;
   localparam logic [11:0] TAP_DIV1024 = 12'h3ff;
   localparam logic [11:0] TAP_DIV4096 = 12'hfff;

   typedef enum logic [0:0] {
      MODE_RELOAD = 1'b0,
      MODE_GUARD = 1'b1
   } rtw_mode_type;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rtw_req_type;

   typedef struct packed {
      rtw_mode_type mode;
      logic next_code;
      logic guard_run;
      logic reload_run;
      logic [2:0] clk_sel;
      logic [7:0] count;
      logic [7:0] reload;
      logic [PRESC_W-1:0] presc;
      logic [7:0] rdata;
      logic [7:0] status;
      logic [7:0] mask;
      logic irq;
      logic guard_reset;
   } rtw_state_type;

endpackage : rtw_pkg

// ===== design/rtw_top.sv
// How it works
// RL1: Eight-bit counter advances on each count tick
// RL2: Reload mode overflow raises interrupt and reloads
// RL3: Watchdog mode overflow resets the whole system
// RL4: Counter write also stores value into reload
// RL5: Running watchdog ignores plain counter writes
// RL6: Reload register read-only in watchdog mode
// RL7: Control bits 4-6 unwritable, bit 4 reads one
// RL8: Any reset sets control to 10H
// RL9: Bits 0-2 select timebase divisor 8..4096
// RL10: Bit 3 runs reload mode, watchdog just readback
// RL11: Bit 5 shows watchdog counting
// RL12: Alternate 3 and C codes reload counter
// RL13: Bit 6 shows next expected service code
// RL14: Bit 7 selects reload or watchdog mode
// RL15: Watchdog mode locks clock select and reload
// RL16: Software programs period before entering watchdog
// RL17: First 3 code starts watchdog, count unchanged
// RL18: Watchdog mode sticks until system reset
// RL19: Tick enable from prescaler tap, FF wraps
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module rtw_top (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Timebase clock enable, one cycle per timebase period
   input wire logic timebase_clock_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Events
   output logic irq_o,
   output logic guard_reset_o
);

   rtw_pkg::rtw_req_type req;
   rtw_pkg::rtw_state_type cur_ff;
   rtw_pkg::rtw_state_type nxt_ff;
   rtw_pkg::rtw_state_type init_val;

   logic [rtw_pkg::PRESC_W-1:0] tap_mask;
   logic count_tick;
   logic counting;
   logic overflow;
   logic [7:0] ctl_read;
   logic svc_ok;

   assign req.addr = reg_addr_i;
   assign req.wdata = reg_wdata_i;
   assign req.wr = reg_wr_i;
   assign req.rd = reg_rd_i;

   always_comb begin
      init_val = '0;
      init_val.mode = rtw_pkg::MODE_RELOAD;
      init_val.clk_sel = rtw_pkg::CONTROL_RESET[rtw_pkg::CTL_SEL_LSB +: 3];
      init_val.reload_run = rtw_pkg::CONTROL_RESET[rtw_pkg::CTL_RUN_BIT];
      init_val.guard_run = rtw_pkg::CONTROL_RESET[rtw_pkg::CTL_GRUN_BIT];
      init_val.next_code = rtw_pkg::CONTROL_RESET[rtw_pkg::CTL_NEXT_BIT];
      init_val.count = rtw_pkg::COUNT_RESET;
      init_val.reload = rtw_pkg::RELOAD_RESET;
      init_val.mask = rtw_pkg::MASK_RESET;
   end

   // Prescaler tap per clock select
   always_comb begin
      case (cur_ff.clk_sel) // RL9
         3'h0: tap_mask = rtw_pkg::TAP_DIV8;
         3'h1: tap_mask = rtw_pkg::TAP_DIV16;
         3'h2: tap_mask = rtw_pkg::TAP_DIV32;
         3'h3: tap_mask = rtw_pkg::TAP_DIV64;
         3'h4: tap_mask = rtw_pkg::TAP_DIV128;
         3'h5: tap_mask = rtw_pkg::TAP_DIV256;
         3'h6: tap_mask = rtw_pkg::TAP_DIV1024;
         default: tap_mask = rtw_pkg::TAP_DIV4096;
      endcase
   end

   // One-cycle count enable when all tap bits are ones
   assign count_tick = timebase_clock_i && ((cur_ff.presc & tap_mask) == tap_mask); // RL19

   assign counting = (cur_ff.mode == rtw_pkg::MODE_GUARD) ? cur_ff.guard_run // RL10
                                                          : cur_ff.reload_run;
   assign overflow = counting && count_tick && (cur_ff.count == rtw_pkg::COUNT_MAX); // RL19

   // Control readback
   always_comb begin
      ctl_read = '0;
      ctl_read[rtw_pkg::CTL_SEL_LSB +: 3] = cur_ff.clk_sel;
      ctl_read[rtw_pkg::CTL_RUN_BIT] = cur_ff.reload_run;
      ctl_read[rtw_pkg::CTL_ONE_BIT] = 1'b1; // RL7
      ctl_read[rtw_pkg::CTL_GRUN_BIT] = cur_ff.guard_run; // RL11
      ctl_read[rtw_pkg::CTL_NEXT_BIT] = cur_ff.next_code; // RL13
      ctl_read[rtw_pkg::CTL_MODE_BIT] = cur_ff.mode;
   end

   // Service write matches expected code
   assign svc_ok = cur_ff.next_code ? (req.wdata[3:0] == rtw_pkg::SERVICE_SECOND)
                                    : (req.wdata[3:0] == rtw_pkg::SERVICE_FIRST); // RL12

   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.guard_reset = 1'b0;
      nxt_ff.rdata = '0;

      if (timebase_clock_i) begin
         nxt_ff.presc = cur_ff.presc + 1'b1;
      end

      // Counting and overflow
      if (counting && count_tick) begin
         nxt_ff.count = cur_ff.count + 1'b1; // RL1
         if (overflow) begin
            if (cur_ff.mode == rtw_pkg::MODE_RELOAD) begin
               nxt_ff.count = cur_ff.reload; // RL2
               nxt_ff.status[rtw_pkg::STAT_OVF_BIT] = 1'b1; // RL2
            end
         end
      end

      // Register writes
      if (req.wr) begin
         if (req.addr == rtw_pkg::ADDR_CONTROL) begin
            nxt_ff.reload_run = req.wdata[rtw_pkg::CTL_RUN_BIT]; // RL10
            if (cur_ff.mode == rtw_pkg::MODE_RELOAD) begin // RL18
               nxt_ff.clk_sel = req.wdata[rtw_pkg::CTL_SEL_LSB +: 3]; // RL15
               nxt_ff.mode = rtw_pkg::rtw_mode_type'(req.wdata[rtw_pkg::CTL_MODE_BIT]); // RL14
            end
         end else if (req.addr == rtw_pkg::ADDR_COUNT) begin
            if (cur_ff.mode == rtw_pkg::MODE_RELOAD) begin
               nxt_ff.count = req.wdata; // RL4
               nxt_ff.reload = req.wdata; // RL4
            end else if (!cur_ff.guard_run) begin
               if (req.wdata[3:0] == rtw_pkg::SERVICE_FIRST) begin
                  nxt_ff.guard_run = 1'b1; // RL17
                  nxt_ff.next_code = 1'b1; // RL17
               end
            end else if (svc_ok) begin
               nxt_ff.count = cur_ff.reload; // RL12
               nxt_ff.next_code = ~cur_ff.next_code; // RL12
            end
         end else if (req.addr == rtw_pkg::ADDR_RELOAD) begin
            if (cur_ff.mode == rtw_pkg::MODE_RELOAD) begin
               nxt_ff.reload = req.wdata; // RL6
            end
         end else if (req.addr == rtw_pkg::ADDR_MASK) begin
            nxt_ff.mask = req.wdata;
         end
      end

      // Register reads; status clears on read, a new event wins
      if (req.rd) begin
         if (req.addr == rtw_pkg::ADDR_CONTROL) begin
            nxt_ff.rdata = ctl_read;
         end else if (req.addr == rtw_pkg::ADDR_COUNT) begin
            nxt_ff.rdata = cur_ff.count; // RL5
         end else if (req.addr == rtw_pkg::ADDR_RELOAD) begin
            nxt_ff.rdata = cur_ff.reload;
         end else if (req.addr == rtw_pkg::ADDR_MASK) begin
            nxt_ff.rdata = cur_ff.mask;
         end else if (req.addr == rtw_pkg::ADDR_STATUS) begin
            nxt_ff.rdata = cur_ff.status;
            nxt_ff.status = '0;
            if (overflow && cur_ff.mode == rtw_pkg::MODE_RELOAD) begin
               nxt_ff.status[rtw_pkg::STAT_OVF_BIT] = 1'b1;
            end
         end else begin
            nxt_ff.rdata = '0;
         end
      end

      nxt_ff.irq = |(nxt_ff.status & nxt_ff.mask);

      // Watchdog overflow: pulse system reset, return to reset state
      if (overflow && cur_ff.mode == rtw_pkg::MODE_GUARD) begin
         nxt_ff = init_val; // RL3
         nxt_ff.guard_reset = 1'b1; // RL3
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cur_ff <= init_val; // RL8
      end else begin
         cur_ff <= nxt_ff; // RL18
      end
   end

   assign reg_rdata_o = cur_ff.rdata;
   assign irq_o = cur_ff.irq;
   assign guard_reset_o = cur_ff.guard_reset;

endmodule : rtw_top

`default_nettype wire

// ===== testbench/rtw_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module rtw_monitor (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Observed ports
   input wire logic timebase_clock_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic irq_o,
   input wire logic guard_reset_o
);
   default clocking mon_cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence ctl_read;
      reg_rd_i && reg_addr_i == rtw_pkg::ADDR_CONTROL ##1 1'b1;
   endsequence
   sequence void_read;
      reg_rd_i && reg_addr_i[7:3] != 5'h0f ##1 1'b1;
   endsequence

   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data not zero outside read slot");
   a_ctl_one: assert property (ctl_read |-> reg_rdata_o[4])
      else $error("control bit 4 read as zero");
   a_void_read: assert property (void_read |-> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_reload_flags: assert property (ctl_read |-> reg_rdata_o[7] || reg_rdata_o[6:5] == 2'b00)
      else $error("guard flags set in reload mode");
   a_code_idle: assert property (ctl_read |-> reg_rdata_o[5] || !reg_rdata_o[6])
      else $error("next code flag set while guard idle");
   a_guard_pulse: assert property (guard_reset_o |=> !guard_reset_o)
      else $error("guard reset longer than one cycle");
   a_guard_tick: assert property (guard_reset_o |-> $past(timebase_clock_i))
      else $error("guard reset without count tick");
   a_irq_cause: assert property ($rose(irq_o) |->
      $past(timebase_clock_i) || $past(reg_wr_i))
      else $error("interrupt rose without cause");
endmodule : rtw_monitor

bind rtw_top rtw_monitor rtw_monitor_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
   .timebase_clock_i(timebase_clock_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .guard_reset_o(guard_reset_o));

`default_nettype wire

// ===== testbench/test_reload_timer_with_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module test_reload_timer_with_watchdog;
   localparam logic [7:0] ST = rtw_pkg::ADDR_STATUS;
   localparam logic [7:0] MK = rtw_pkg::ADDR_MASK;
   localparam logic [7:0] CN = rtw_pkg::ADDR_COUNT;
   localparam logic [7:0] RL = rtw_pkg::ADDR_RELOAD;
   localparam logic [7:0] CT = rtw_pkg::ADDR_CONTROL;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic tb_pulse = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic irq;
   logic guard;
   logic [1:0] ev;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;

   always #12.5 core_clk_i = ~core_clk_i;

   rtw_top rtw_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .timebase_clock_i(tb_pulse),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .irq_o(irq), .guard_reset_o(guard));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1 check(rdata, exp);
   endtask : rd_reg

   // Timebase pulses every other cycle until an interrupt or guard reset shows
   // Event as {guard, irq}, cycles spent in n
   task automatic pulse_until(output int n);
      ev = 2'b00;
      n = 0;
      while (n < 100 && ev === 2'b00) begin
         @(posedge core_clk_i);
         tb_pulse <= ~tb_pulse;
         #1 ev = {guard, irq};
         n++;
      end
      @(posedge core_clk_i);
      tb_pulse <= 1'b0;
   endtask : pulse_until

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge core_clk_i);
      #1 check({7'h00, irq}, {7'h00, exp});
   endtask : irq_is

   task automatic t_ctl_fields();
      rd_reg(CT, 8'h10);
      rd_reg(8'h00, 8'h00);
      wr_reg(CT, 8'h6f);
      rd_reg(CT, 8'h1f);
      wr_reg(CT, 8'h00);
   endtask : t_ctl_fields

   task automatic t_reload_irq();
      int n;
      wr_reg(CN, 8'hfe);
      rd_reg(RL, 8'hfe);
      wr_reg(RL, 8'h55);
      wr_reg(MK, 8'h01);
      wr_reg(CT, 8'h08);
      pulse_until(n);
      check({6'h00, ev}, 8'h01);
      check(n[7:0], 8'h20);
      wr_reg(CT, 8'h00);
      rd_reg(CN, 8'h55);
      wr_reg(MK, 8'h00);
      irq_is(1'b0);
      rd_reg(ST, 8'h01);
      rd_reg(ST, 8'h00);
      wr_reg(MK, 8'h01);
      irq_is(1'b0);
   endtask : t_reload_irq

   task automatic t_rerun();
      int n;
      // Divide by 16; prescaler sits on a multiple of 16 here
      wr_reg(CN, 8'hfe);
      wr_reg(CT, 8'h09);
      pulse_until(n);
      check({6'h00, ev}, 8'h01);
      check(n[7:0], 8'h40);
      @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      rd_reg(CT, 8'h10);
      rd_reg(MK, 8'h00);
      rd_reg(ST, 8'h00);
      rd_reg(CN, 8'h00);
   endtask : t_rerun

   task automatic t_guard();
      int n;
      wr_reg(CN, 8'h40);
      wr_reg(RL, 8'hfe);
      wr_reg(CT, 8'h80);
      rd_reg(CT, 8'h90);
      wr_reg(RL, 8'h11);
      rd_reg(RL, 8'hfe);
      wr_reg(CT, 8'h0d);
      rd_reg(CT, 8'h98);
      wr_reg(CN, 8'h47);
      rd_reg(CN, 8'h40);
      wr_reg(CN, 8'ha3);
      rd_reg(CT, 8'hf8);
      rd_reg(CN, 8'h40);
      wr_reg(CN, 8'h5c);
      rd_reg(CN, 8'hfe);
      rd_reg(CT, 8'hb8);
      wr_reg(CN, 8'h2c);
      rd_reg(CT, 8'hb8);
      rd_reg(CN, 8'hfe);
      pulse_until(n);
      check({6'h00, ev}, 8'h02);
      check(n[7:0], 8'h20);
      rd_reg(CT, 8'h10);
   endtask : t_guard

   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end

   initial begin
      repeat (20) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      t_ctl_fields();
      t_reload_irq();
      t_rerun();
      t_guard();
      final_report();
   end
endmodule : test_reload_timer_with_watchdog

`default_nettype wire
